// ==== hdl/dcfpf_map.vh ====
// constants for the dual-clock fifo port flag block
`ifndef DCFPF_MAP_VH
`define DCFPF_MAP_VH

// avalon register byte offsets
`define DCFPF_REG_STATUS 4'h0
`define DCFPF_REG_AE_OFS 4'h4
`define DCFPF_REG_AF_OFS 4'h8

// status word field positions
`define DCFPF_ST_READY_IN 0
`define DCFPF_ST_READY_OUT 1
`define DCFPF_ST_ALMOST_EMPTY 2
`define DCFPF_ST_ALMOST_FULL 3
`define DCFPF_ST_FALL_THROUGH 4
`define DCFPF_ST_LEVEL_LSB 16

// reset values of the offset registers
`define DCFPF_AE_OFS_RESET 16'h0008
`define DCFPF_AF_OFS_RESET 16'h0008

// edge of the port clock (after release) that samples the mode pin
`define DCFPF_MODE_SAMPLE_EDGE 2'h2

// skew windows in ns; the two-stage pin sync already exceeds them at 40 MHz
`define DCFPF_CLOCK_NS 25
`define DCFPF_FLAG_SKEW_WINDOW_1_NS 5
`define DCFPF_FLAG_SKEW_WINDOW_2_NS 10

`endif

// ==== hdl/dcfpf_top.v ====
// dual-clock fifo with port qualification, flags and avalon status slave
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dcfpf_map.vh"

//////////////////////////////////////////////////////////////////////////////
module dcfpf_top #(
  parameter AW = 10, // log2 of queue depth (1024 default)
  parameter DW = 36  // long-word width
) (
  input wire clock,
  input wire rst,
  input wire clk_en,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // pins from the outside, asynchronous to clock
  input wire master_reset_n_1,
  input wire endian_or_timing_pin,
  input wire a_side_clock,
  input wire a_side_select_n,
  input wire a_side_dir,
  input wire a_side_xfer_go,
  input wire a_side_mail_sel,
  input wire [DW-1:0] a_side_data_in,
  output reg [DW-1:0] a_side_data_out,
  output reg a_side_data_oe,
  input wire b_side_clock,
  input wire b_side_select_n,
  input wire b_side_dir,
  input wire b_side_xfer_go,
  input wire b_side_mail_sel,
  output reg [DW-1:0] b_side_data_out,
  output reg b_side_data_oe,
  // second mail register contents from on-chip logic
  input wire [DW-1:0] mail2_contents,
  // flags
  output reg full_or_input_ready,
  output reg empty_or_output_ready,
  output reg almost_empty,
  output reg almost_full,
  output reg fall_through_mode
);

  localparam PW = AW + 1; // pointer width with wrap bit
  localparam DEPTH = 1 << AW;
  localparam [PW-1:0] DEPTH_P = DEPTH[PW-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // binary to gray, used for both pointers
  function [PW-1:0] to_gray;
    input [PW-1:0] b;
    begin
      to_gray = b ^ (b >> 1);
    end
  endfunction

  // gray to binary, used on both synchronised pointers
  function [PW-1:0] from_gray;
    input [PW-1:0] g;
    integer i;
    begin
      from_gray[PW-1] = g[PW-1];
      for (i = PW - 2; i >= 0; i = i - 1) begin
        from_gray[i] = from_gray[i+1] ^ g[i];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every outside pin passes two flops

  reg [1:0] a_clk_sync; // a-side clock stages
  reg a_clk_prev; // edge detect on synced level only
  reg [1:0] b_clk_sync; // b-side clock stages
  reg b_clk_prev;
  reg [1:0] mrst_sync; // master reset stages
  reg [1:0] mode_sync; // mode pin stages
  reg [4:0] a_ctl_s1; // a controls first stage
  reg [4:0] a_ctl_s2; // a controls second stage
  reg [3:0] b_ctl_s1;
  reg [3:0] b_ctl_s2;
  reg [DW-1:0] a_dat_s1;
  reg [DW-1:0] a_dat_s2;

  // sample pins; second stage is all that logic reads
  always @(posedge clock) begin
    if (rst) begin
      a_clk_sync <= 2'h0;
      a_clk_prev <= 1'b0;
      b_clk_sync <= 2'h0;
      b_clk_prev <= 1'b0;
      mrst_sync <= 2'h0;
      mode_sync <= 2'h0;
      a_ctl_s1 <= 5'h01;
      a_ctl_s2 <= 5'h01;
      b_ctl_s1 <= 4'h1;
      b_ctl_s2 <= 4'h1;
      a_dat_s1 <= {DW{1'b0}};
      a_dat_s2 <= {DW{1'b0}};
    end else if (clk_en) begin
      a_clk_sync <= {a_clk_sync[0], a_side_clock};
      a_clk_prev <= a_clk_sync[1];
      b_clk_sync <= {b_clk_sync[0], b_side_clock};
      b_clk_prev <= b_clk_sync[1];
      mrst_sync <= {mrst_sync[0], master_reset_n_1};
      mode_sync <= {mode_sync[0], endian_or_timing_pin};
      a_ctl_s1 <= {a_side_mail_sel, a_side_xfer_go, a_side_dir, 1'b0, a_side_select_n};
      a_ctl_s2 <= a_ctl_s1;
      b_ctl_s1 <= {b_side_mail_sel, b_side_xfer_go, b_side_dir, b_side_select_n};
      b_ctl_s2 <= b_ctl_s1;
      a_dat_s1 <= a_side_data_in;
      a_dat_s2 <= a_dat_s1;
    end
  end

  // rising edges of the port clocks, as seen from clock
  wire a_edge = clk_en & a_clk_sync[1] & ~a_clk_prev;
  wire b_edge = clk_en & b_clk_sync[1] & ~b_clk_prev;
  wire mrst_low = ~mrst_sync[1];
  wire a_sel_n = a_ctl_s2[0];
  wire a_dir = a_ctl_s2[2];
  wire a_go = a_ctl_s2[3];
  wire a_mail = a_ctl_s2[4];
  wire b_sel_n = b_ctl_s2[0];
  wire b_dir = b_ctl_s2[1];
  wire b_go = b_ctl_s2[2];
  wire b_mail = b_ctl_s2[3];

  //////////////////////////////////////////////////////////////////////////////
  // storage and pointers

  reg [DW-1:0] mem [0:DEPTH-1]; // queue storage, flops
  reg [PW-1:0] wr_bin; // write pointer, a-side
  reg [PW-1:0] wr_gray;
  reg [PW-1:0] rd_bin; // read pointer, b-side
  reg [PW-1:0] rd_gray;
  reg [PW-1:0] wg_s1; // write gray into b-side, stage 1
  reg [PW-1:0] wg_s2;
  reg [PW-1:0] rg_s1; // read gray into a-side, stage 1
  reg [PW-1:0] rg_s2;
  reg [15:0] ae_offset; // software: almost-empty offset
  reg [15:0] af_offset; // software: almost-full offset
  reg [1:0] mode_cnt; // a-edges since master reset release
  reg mode_done;

  // qualified requests; select and dir only count with go high
  wire a_write = a_go & ~a_sel_n & a_dir & ~a_mail & full_or_input_ready;
  wire b_read = b_go & ~b_sel_n & b_dir & ~b_mail & empty_or_output_ready;

  // write side on a-edges only, never touches b-side state
  wire [PW-1:0] next_wr_bin = wr_bin + {{AW{1'b0}}, a_write};
  wire [PW-1:0] next_rg_s2 = rg_s1;
  wire [PW-1:0] wr_level = next_wr_bin - from_gray(next_rg_s2);
  wire [PW-1:0] af_limit = DEPTH_P - af_offset[PW-1:0];

  // a-side pointer, memory and write-clock flags
  always @(posedge clock) begin
    if (rst || mrst_low) begin
      wr_bin <= {PW{1'b0}};
      wr_gray <= {PW{1'b0}};
      rg_s1 <= {PW{1'b0}};
      rg_s2 <= {PW{1'b0}};
      full_or_input_ready <= 1'b0;
      almost_full <= 1'b1;
    end else if (a_edge) begin
      if (a_write) begin
        mem[wr_bin[AW-1:0]] <= a_dat_s2;
      end
      wr_bin <= next_wr_bin;
      wr_gray <= to_gray(next_wr_bin);
      // two-edge crossing of the read pointer
      rg_s1 <= rd_gray;
      rg_s2 <= next_rg_s2;
      // freed slot shows on the second a-edge after the read
      full_or_input_ready <= (wr_level != DEPTH_P);
      almost_full <= (wr_level < af_limit);
    end
  end

  // mode pin capture at the second a-edge after release
  always @(posedge clock) begin
    if (rst || mrst_low) begin
      mode_cnt <= 2'h0;
      mode_done <= 1'b0;
      fall_through_mode <= 1'b1;
    end else if (a_edge && !mode_done) begin
      mode_cnt <= mode_cnt + 2'h1;
      if (mode_cnt + 2'h1 == `DCFPF_MODE_SAMPLE_EDGE) begin
        fall_through_mode <= ~mode_sync[1];
        mode_done <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read side on b-edges

  wire [PW-1:0] next_wg_s2 = wg_s1;
  wire [PW-1:0] wr_seen = from_gray(wg_s2); // value at this edge
  wire have_word = (wr_seen != rd_bin); // memory holds an unread word
  reg do_load; // word moves to output register
  reg next_ready_out;

  // choose load and next ready state per mode
  always @* begin
    do_load = 1'b0;
    next_ready_out = empty_or_output_ready;
    if (fall_through_mode) begin
      if (!empty_or_output_ready) begin
        // first word falls through on the edge that raises ready
        do_load = have_word;
        next_ready_out = have_word;
      end else if (b_read) begin
        do_load = have_word;
        next_ready_out = have_word;
      end
    end else begin
      do_load = b_read;
      next_ready_out = 1'b0;
    end
  end

  wire [PW-1:0] next_rd_bin = rd_bin + {{AW{1'b0}}, do_load};
  wire [PW-1:0] rd_level = from_gray(next_wg_s2) - next_rd_bin;

  // b-side pointer, output register and read-clock flags
  always @(posedge clock) begin
    if (rst || mrst_low) begin
      rd_bin <= {PW{1'b0}};
      rd_gray <= {PW{1'b0}};
      wg_s1 <= {PW{1'b0}};
      wg_s2 <= {PW{1'b0}};
      empty_or_output_ready <= 1'b0;
      almost_empty <= 1'b0;
      b_side_data_out <= {DW{1'b0}};
    end else if (b_edge) begin
      if (do_load) begin
        b_side_data_out <= mem[rd_bin[AW-1:0]];
      end
      rd_bin <= next_rd_bin;
      rd_gray <= to_gray(next_rd_bin);
      wg_s1 <= wr_gray;
      wg_s2 <= next_wg_s2;
      if (fall_through_mode) begin
        empty_or_output_ready <= next_ready_out;
      end else begin
        // empty flag rises on the second b-edge after the write
        empty_or_output_ready <= (from_gray(next_wg_s2) != next_rd_bin);
      end
      almost_empty <= (rd_level > ae_offset[PW-1:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data line drive; follows select and dir every cycle, not just on edges

  // enables and mail drive
  always @(posedge clock) begin
    if (rst) begin
      a_side_data_oe <= 1'b0;
      a_side_data_out <= {DW{1'b0}};
      b_side_data_oe <= 1'b0;
    end else if (clk_en) begin
      a_side_data_oe <= ~a_sel_n & ~a_dir;
      a_side_data_out <= mail2_contents;
      b_side_data_oe <= ~b_sel_n & b_dir;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one cycle of wait, then one cycle with waitrequest low

  wire bus_req = avs_read | avs_write;
  reg [31:0] next_readdata;

  // read mux; unmapped offsets read zero
  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address)
      `DCFPF_REG_STATUS: begin
        next_readdata[`DCFPF_ST_READY_IN] = full_or_input_ready;
        next_readdata[`DCFPF_ST_READY_OUT] = empty_or_output_ready;
        next_readdata[`DCFPF_ST_ALMOST_EMPTY] = almost_empty;
        next_readdata[`DCFPF_ST_ALMOST_FULL] = almost_full;
        next_readdata[`DCFPF_ST_FALL_THROUGH] = fall_through_mode;
        next_readdata[`DCFPF_ST_LEVEL_LSB +: PW] = wr_bin - from_gray(rg_s2);
      end
      `DCFPF_REG_AE_OFS: begin
        next_readdata[15:0] = ae_offset;
      end
      `DCFPF_REG_AF_OFS: begin
        next_readdata[15:0] = af_offset;
      end
      default: begin
        next_readdata = 32'h00000000;
      end
    endcase
  end

  // handshake; a write lands on the edge that sees waitrequest low
  always @(posedge clock) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ae_offset <= `DCFPF_AE_OFS_RESET;
      af_offset <= `DCFPF_AF_OFS_RESET;
    end else if (clk_en) begin
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= next_readdata;
      end else begin
        avs_waitrequest <= 1'b1;
        if (avs_write && !avs_waitrequest) begin
          if (avs_address == `DCFPF_REG_AE_OFS) begin
            ae_offset <= avs_writedata[15:0];
          end
          if (avs_address == `DCFPF_REG_AF_OFS) begin
            af_offset <= avs_writedata[15:0];
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== testbench/dcfpf_props.sv ====
// port-level assertions for the dual-clock fifo port flag block
`timescale 1ns/1ps
`default_nettype none
module dcfpf_props #(
  parameter AW = 10,
  parameter DW = 36
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic master_reset_n_1,
  input wire logic a_side_clock,
  input wire logic a_side_select_n,
  input wire logic a_side_dir,
  input wire logic [DW-1:0] a_side_data_out,
  input wire logic a_side_data_oe,
  input wire logic b_side_clock,
  input wire logic b_side_select_n,
  input wire logic b_side_dir,
  input wire logic [DW-1:0] b_side_data_out,
  input wire logic b_side_data_oe,
  input wire logic [DW-1:0] mail2_contents,
  input wire logic full_or_input_ready,
  input wire logic empty_or_output_ready,
  input wire logic almost_empty,
  input wire logic almost_full,
  input wire logic fall_through_mode
);
  // all checks live in the system clock domain; a master reset pauses them
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst || !master_reset_n_1);
  // a taken request is answered by one low cycle, then high again
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_answer: assert property (avs_waitrequest && (avs_read || avs_write) |=> s_answer)
    else $error("bus answer not a single cycle");
  a_a_drive: assert property ((!a_side_select_n && !a_side_dir) [*5] |-> a_side_data_oe)
    else $error("a side not driven while selected for read");
  a_a_float: assert property ((a_side_select_n || a_side_dir) [*5] |-> !a_side_data_oe)
    else $error("a side driven while released");
  a_b_drive: assert property ((!b_side_select_n && b_side_dir) [*5] |-> b_side_data_oe)
    else $error("b side not driven while selected");
  a_b_float: assert property ((b_side_select_n || !b_side_dir) [*5] |-> !b_side_data_oe)
    else $error("b side driven while released");
  a_mail_copy: assert property (!$past(rst) && $past(master_reset_n_1, 4)
    |-> a_side_data_out == $past(mail2_contents))
    else $error("a side data is not the mail word");
  a_std_hold: assert property (!fall_through_mode && !empty_or_output_ready
    |=> $stable(b_side_data_out))
    else $error("output word moved while empty");
  a_ft_hold: assert property (fall_through_mode && !empty_or_output_ready
    |=> $stable(b_side_data_out) || $rose(empty_or_output_ready))
    else $error("output word moved without ready rising");
  a_ir_edge: assert property ($rose(full_or_input_ready) |-> $past(a_side_clock, 2))
    else $error("input ready rose off a write clock edge");
  a_or_edge: assert property ($rose(empty_or_output_ready) |-> $past(b_side_clock, 2))
    else $error("empty flag rose off a read clock edge");
  a_ae_edge: assert property ($rose(almost_empty) |-> $past(b_side_clock, 2))
    else $error("almost empty rose off a read clock edge");
  a_af_edge: assert property ($fell(almost_full) |-> $past(a_side_clock, 2))
    else $error("almost full fell off a write clock edge");
endmodule
bind dcfpf_top dcfpf_props #(.AW(AW), .DW(DW)) u_props (.*);
`default_nettype wire

// ==== testbench/dcfpf_port_model.sv ====
// port-side party model: one framed port clock cycle per request
`timescale 1ns/1ps
`default_nettype none
module dcfpf_port_model (
  input wire logic clock,
  input wire logic req,
  input wire logic [3:0] ctl,
  input wire logic [35:0] word,
  output logic pclk,
  output logic [3:0] pins,
  output logic [35:0] pdata,
  output logic busy
);
  logic [3:0] cnt; // phase within one port cycle
  // idle: deselected, port clock still
  initial begin
    pclk = 1'b0;
    pins = 4'h8;
    pdata = 36'h0;
    busy = 1'b0;
    cnt = 4'h0;
  end
  // controls settle four cycles before the edge, so two sync stages see them
  always @(posedge clock) begin
    if (!busy && req) begin
      busy <= 1'b1;
      pins <= ctl;
      pdata <= word;
      cnt <= 4'h0;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
      pclk <= cnt >= 4'h3 && cnt < 4'h7;
      // released data shows the inverse so a stale word never passes
      if (cnt == 4'hB) begin
        busy <= 1'b0;
        pins <= 4'h8;
        pdata <= ~pdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking testbench for the dual-clock fifo port flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic mr_n = 1'b0;
  logic mode_pin = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, fir, eor, ae, af, ftm;
  logic [35:0] mail2 = 36'h0;
  logic [35:0] word = 36'h0;
  logic [35:0] a_out, b_out;
  logic [1:0] req = 2'h0;
  logic [1:0] pclk, busy, oe;
  logic [3:0] ctl [2] = '{4'h8, 4'h8};
  logic [3:0] pins [2];
  logic [35:0] pdata [2];
  int bad_count = 0;
  int samples_checked = 0;
  always #12.5 clock = ~clock;
  dcfpf_port_model u_wr (.clock(clock), .req(req[0]), .ctl(ctl[0]), .word(word), .pclk(pclk[0]),
    .pins(pins[0]), .pdata(pdata[0]), .busy(busy[0]));
  dcfpf_port_model u_rd (.clock(clock), .req(req[1]), .ctl(ctl[1]), .word(word), .pclk(pclk[1]),
    .pins(pins[1]), .pdata(pdata[1]), .busy(busy[1]));
  // depth of eight keeps the full and drain runs short
  dcfpf_top #(.AW(3), .DW(36)) u_dut (.clock(clock), .rst(rst), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .master_reset_n_1(mr_n), .endian_or_timing_pin(mode_pin),
    .a_side_clock(pclk[0]), .a_side_select_n(pins[0][3]), .a_side_dir(pins[0][2]), .a_side_xfer_go(pins[0][1]),
    .a_side_mail_sel(pins[0][0]), .a_side_data_in(pdata[0]), .a_side_data_out(a_out), .a_side_data_oe(oe[0]),
    .b_side_clock(pclk[1]), .b_side_select_n(pins[1][3]), .b_side_dir(pins[1][2]), .b_side_xfer_go(pins[1][1]),
    .b_side_mail_sel(pins[1][0]), .b_side_data_out(b_out), .b_side_data_oe(oe[1]), .mail2_contents(mail2),
    .full_or_input_ready(fir), .empty_or_output_ready(eor), .almost_empty(ae), .almost_full(af),
    .fall_through_mode(ftm));
  function automatic logic [35:0] wd(input int i);
    return 36'h123456789 + 36'h101010101 * 36'(i);
  endfunction
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic rchk(input logic [3:0] adr, input logic [31:0] m, input logic [31:0] exp, input string what);
    bus(1'b0, adr, 32'h0);
    chk(what, {4'h0, exp}, {4'h0, rd & m});
  endtask
  // one port clock cycle on side s with controls c
  task automatic port(input int s, input logic [3:0] c, input logic [35:0] w);
    int n;
    n = 0;
    @(posedge clock);
    ctl[s] <= c;
    word <= w;
    req[s] <= 1'b1;
    repeat (2) @(posedge clock);
    req[s] <= 1'b0;
    while (busy[s] !== 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    mr_n <= 1'b1;
    rchk(4'h4, 32'hFFFF, 32'h8, "ae_ofs");
    rchk(4'h8, 32'hFFFF, 32'h8, "af_ofs");
    bus(1'b1, 4'h4, 32'h2);
    bus(1'b1, 4'h8, 32'h2);
    bus(1'b1, 4'hC, 32'h5);
    rchk(4'h4, 32'hFFFF, 32'h2, "ae_ofs_rw");
    rchk(4'hC, 32'hFFFFFFFF, 32'h0, "unmapped");
    port(0, 4'h8, 36'h0);
    port(0, 4'h8, 36'h0);
    rchk(4'h0, 32'hF001F, 32'h9, "status_std");
    for (int i = 0; i < 3; i++) begin
      port(0, 4'h6, wd(i));
    end
    chk("ef_early", 36'h0, eor);
    port(1, 4'h8, 36'h0);
    chk("ef_edge1", 36'h0, eor);
    port(1, 4'h8, 36'h0);
    chk("ef_edge2", 36'h1, eor);
    chk("ae_high", 36'h1, ae);
    port(1, 4'hE, 36'h0);
    port(1, 4'h7, 36'h0);
    port(1, 4'h4, 36'h0);
    chk("no_load", 36'h0, b_out);
    for (int i = 0; i < 3; i++) begin
      port(1, 4'h6, 36'h0);
      chk("read_order", wd(i), b_out);
    end
    port(1, 4'h6, 36'h0);
    chk("ef_drained", 36'h0, eor);
    chk("ae_low", 36'h0, ae);
    chk("hold_empty", wd(2), b_out);
    for (int i = 10; i < 19; i++) begin
      port(0, 4'h6, wd(i));
    end
    chk("full", 36'h0, fir);
    rchk(4'h0, 32'hF0008, 32'h80000, "level_full");
    port(1, 4'h8, 36'h0);
    port(1, 4'h8, 36'h0);
    port(1, 4'h6, 36'h0);
    port(0, 4'h8, 36'h0);
    chk("ir_edge1", 36'h0, fir);
    port(0, 4'h8, 36'h0);
    chk("ir_edge2", 36'h1, fir);
    for (int i = 11; i < 19; i++) begin
      port(1, 4'h6, 36'h0);
      chk("drain_order", wd(i < 18 ? i : 17), b_out);
    end
    mail2 <= 36'h5A5A5A5A5;
    port(0, 4'h0, 36'h0);
    chk("mail_out", 36'h5A5A5A5A5, a_out);
    mr_n <= 1'b0;
    mode_pin <= 1'b0;
    repeat (8) @(posedge clock);
    mr_n <= 1'b1;
    port(0, 4'h8, 36'h0);
    port(0, 4'h8, 36'h0);
    chk("ft_mode", 36'h1, ftm);
    port(0, 4'h6, wd(30));
    port(1, 4'h8, 36'h0);
    port(1, 4'h8, 36'h0);
    chk("or_edge2", 36'h0, eor);
    port(1, 4'h8, 36'h0);
    chk("or_edge3", 36'h1, eor);
    chk("ft_word", wd(30), b_out);
    give_verdict();
  end
endmodule
`default_nettype wire
